// ---- core/sd_fmt_pkg.sv ----
// Constants shared by the format detector and its payload packet parser.
// Assumes a 10-bit recovered video word stream sampled on clk_i.
// Summary of operation
// RULE1 - Capture four payload identifier words for host
// RULE2 - Status bit 7 shows payload version
// RULE3 - Load payload only on matching checksum
// RULE4 - Ignore payload packets on wrong line
// RULE5 - Clear payload on reset, unlock, bypass
// RULE6 - Bytes 1,2 at 0Fh; 3,4 at 10h
// RULE7 - Measure raster from timing reference words
// RULE8 - Raster registers 11h-14h, right aligned
// RULE9 - Standard lock high once flywheel synchronized
// RULE10 - Raster and lock zero on reset/unlock/bypass
// RULE11 - Format code in status bits 3-0
// RULE12 - Format code table, 6h video, 7h async
// RULE13 - Code Fh on reset, unlock, both modes low
// RULE14 - Status register 04h layout: code, lock, version
// RULE15 - All four payload bytes update together
package sd_fmt_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam logic [7:0] ADDR_STATUS      = 8'h04;
	localparam logic [7:0] ADDR_PID_LOW     = 8'h0f;
	localparam logic [7:0] ADDR_PID_HIGH    = 8'h10;
	localparam logic [7:0] ADDR_TOT_LINES   = 8'h11;
	localparam logic [7:0] ADDR_TOT_WORDS   = 8'h12;
	localparam logic [7:0] ADDR_ACT_WORDS   = 8'h13;
	localparam logic [7:0] ADDR_ACT_LINES   = 8'h14;
	localparam int STAT_LOCK_BIT    = 4;
	localparam int STAT_VERSION_BIT = 7;
	localparam int LINE_W = 11;
	localparam int WORD_W = 13;
	localparam logic [9:0] WORD_ONES  = 10'h3ff;
	localparam logic [9:0] WORD_ZEROS = 10'h000;
	localparam int XYZ_F_BIT = 8;
	localparam int XYZ_V_BIT = 7;
	localparam int XYZ_H_BIT = 6;
	localparam logic [7:0] PID_DID   = 8'h41;
	localparam logic [7:0] PID_SDID  = 8'h01;
	localparam logic [7:0] PID_COUNT = 8'h04;
	localparam int PID_VERSION_BIT = 7;
	localparam logic [3:0] FMT_VIDEO   = 4'h6;
	localparam logic [3:0] FMT_ASYNC   = 4'h7;
	localparam logic [3:0] FMT_UNKNOWN = 4'hf;
	localparam logic [1:0] LOCK_REPEATS = 2'h2;
	// Line numbers count from the first line of field 1 (the F 1->0 line)
	localparam logic [10:0] LINES_525 = 11'h20d;
	localparam logic [10:0] LINES_625 = 11'h271;
	localparam logic [10:0] PID_525_F1 = 11'h00a;
	localparam logic [10:0] PID_525_F2 = 11'h111;
	localparam logic [10:0] PID_625_F1 = 11'h009;
	localparam logic [10:0] PID_625_F2 = 11'h142;
endpackage

// ---- core/payload_packet_parser.sv ----
// Finds payload identifier ancillary packets in the word stream.
// Assumes words arrive with valid_i and that line_ok_i is steady per line.
`timescale 1ns/10ps
`default_nettype none
module payload_packet_parser
	import sd_fmt_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        clear_i,
	input  wire logic        valid_i,
	input  wire logic [9:0]  word_i,
	input  wire logic        line_ok_i,
	output logic      [31:0] bytes_o,
	output logic             version_o
);
	typedef enum logic [2:0] {
		PS_IDLE, PS_ZERO, PS_ONE, PS_DID, PS_SDID, PS_DC, PS_UDW, PS_CS
	} parse_state_t;

	typedef struct packed {
		parse_state_t st;
		logic [8:0]   sum;
		logic [1:0]   idx;
		logic [31:0]  buf_w;
		logic [31:0]  bytes;
		logic         version;
	} parser_t;

	parser_t q;
	parser_t d;

	always_comb begin
		d = q;
		if (valid_i) begin
			case (q.st)
				PS_IDLE: begin
					if (word_i == WORD_ZEROS) d.st = PS_ZERO;
				end
				PS_ZERO: begin
					if (word_i == WORD_ONES) d.st = PS_ONE;
					else if (word_i != WORD_ZEROS) d.st = PS_IDLE;
				end
				PS_ONE: begin
					d.st = (word_i == WORD_ONES) ? PS_DID : PS_IDLE;
				end
				PS_DID: begin
					d.sum = word_i[8:0];
					d.st  = (word_i[7:0] == PID_DID) ? PS_SDID : PS_IDLE;
				end
				PS_SDID: begin
					d.sum = q.sum + word_i[8:0];
					d.st  = (word_i[7:0] == PID_SDID) ? PS_DC : PS_IDLE;
				end
				PS_DC: begin
					d.sum = q.sum + word_i[8:0];
					d.idx = 2'h0;
					d.st  = (word_i[7:0] == PID_COUNT) ? PS_UDW : PS_IDLE;
				end
				PS_UDW: begin
					d.sum = q.sum + word_i[8:0];
					d.buf_w[8*q.idx +: 8] = word_i[7:0]; // RULE1
					d.idx = q.idx + 2'h1;
					if (q.idx == 2'h3) d.st = PS_CS;
				end
				PS_CS: begin
					// Bytes stay in a holding buffer so a reject leaves the old set
					if (word_i[8:0] == q.sum && word_i[9] == ~word_i[8] // RULE3
					    && line_ok_i) begin // RULE4
						d.bytes   = q.buf_w; // RULE15
						d.version = q.buf_w[PID_VERSION_BIT]; // RULE2
					end
					d.st = PS_IDLE;
				end
				default: d.st = PS_IDLE;
			endcase
		end
		if (clear_i) d = '0; // RULE5
	end

	always_ff @(posedge clk_i) begin
		q <= d;
	end

	assign bytes_o   = q.bytes;
	assign version_o = q.version;
endmodule
`default_nettype wire

// ---- core/sd_video_format_detector.sv ----
// Format detector: raster measurement, standard lock, format code,
// payload identifier capture and the read-only host registers.
// Assumes one recovered 10-bit word per cycle that word_valid_i is high.
`timescale 1ns/10ps
`default_nettype none
module sd_video_format_detector
	import sd_fmt_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              reset_n_i,
	input  wire logic [9:0]        video_word_i,
	input  wire logic              word_valid_i,
	input  wire logic              locked_i,
	input  wire logic              video_processing_bypass_n_i,
	input  wire logic              async_transport_mode_in_i,
	input  wire logic [ADDR_W-1:0] reg_addr_i,
	input  wire logic              reg_rd_i,
	output logic      [DATA_W-1:0] reg_rdata_o,
	output logic                   standard_locked_o,
	output logic      [3:0]        data_format_o
);
	typedef struct packed {
		logic [1:0]        trs;
		logic [WORD_W-1:0] wcnt;
		logic [WORD_W-1:0] acnt;
		logic              in_act;
		logic [LINE_W-1:0] lcnt;
		logic [LINE_W-1:0] alcnt;
		logic              f_prev;
		logic              framed;
		logic [WORD_W-1:0] tot_words;
		logic [WORD_W-1:0] act_words;
		logic [LINE_W-1:0] tot_lines;
		logic [LINE_W-1:0] act_lines;
		logic [1:0]        repeats;
		logic              standard_locked;
		logic [3:0]        fmt;
		logic [DATA_W-1:0] rdata;
	} detect_t;

	detect_t q;
	detect_t d;

	logic        run;
	logic        line_ok;
	logic [31:0] pid_bytes;
	logic        pid_version;

	function automatic logic pid_line_ok(
		input logic [LINE_W-1:0] line,
		input logic [LINE_W-1:0] total
	);
		logic ok;
		ok = 1'b0;
		if (total == LINES_525)
			ok = (line == PID_525_F1) || (line == PID_525_F2);
		else if (total == LINES_625)
			ok = (line == PID_625_F1) || (line == PID_625_F2);
		return ok;
	endfunction

	// Measurement only runs while the link is locked and processing is on
	assign run     = locked_i & video_processing_bypass_n_i;
	assign line_ok = pid_line_ok(q.lcnt, q.tot_lines);

	payload_packet_parser payload_packet_parser_i (
		.clk_i     (clk_i),
		.clear_i   (~reset_n_i | ~run), // RULE5
		.valid_i   (word_valid_i),
		.word_i    (video_word_i),
		.line_ok_i (line_ok),
		.bytes_o   (pid_bytes),
		.version_o (pid_version)
	);

	function automatic logic [DATA_W-1:0] read_reg(
		input logic [ADDR_W-1:0] addr,
		input detect_t           s,
		input logic [31:0]       bytes,
		input logic              ver
	);
		logic [DATA_W-1:0] r;
		r = '0;
		case (addr)
			ADDR_STATUS: begin
				r[3:0]             = s.fmt; // RULE11
				r[STAT_LOCK_BIT]    = s.standard_locked; // RULE14
				r[STAT_VERSION_BIT] = ver; // RULE2
			end
			ADDR_PID_LOW: begin
				r = bytes[15:0]; // RULE6
			end
			ADDR_PID_HIGH: begin
				r = bytes[31:16]; // RULE6
			end
			ADDR_TOT_LINES: begin
				r[LINE_W-1:0] = s.tot_lines; // RULE8
			end
			ADDR_TOT_WORDS: begin
				r[WORD_W-1:0] = s.tot_words; // RULE8
			end
			ADDR_ACT_WORDS: begin
				r[WORD_W-1:0] = s.act_words; // RULE8
			end
			ADDR_ACT_LINES: begin
				r[LINE_W-1:0] = s.act_lines; // RULE8
			end
			default: r = '0;
		endcase
		return r;
	endfunction

	always_comb begin
		logic              is_eav;
		logic              f_bit;
		logic              v_bit;
		logic              same;
		logic [DATA_W-1:0] keep_rdata;
		is_eav = 1'b0;
		f_bit  = video_word_i[XYZ_F_BIT];
		v_bit  = video_word_i[XYZ_V_BIT];
		same   = 1'b0;
		keep_rdata = q.rdata;
		d = q;

		if (word_valid_i) begin
			d.wcnt = q.wcnt + 13'h1;
			// Active span ends on the first word of the next timing reference
			if (q.in_act) begin
				if (video_word_i == WORD_ONES) begin
					d.in_act    = 1'b0;
					d.act_words = q.acnt; // RULE7
				end else begin
					d.acnt = q.acnt + 13'h1;
				end
			end
			case (q.trs)
				2'h0: begin
					if (video_word_i == WORD_ONES) d.trs = 2'h1;
				end
				2'h1: begin
					if (video_word_i == WORD_ZEROS) d.trs = 2'h2;
					else if (video_word_i != WORD_ONES) d.trs = 2'h0;
				end
				2'h2: begin
					d.trs = (video_word_i == WORD_ZEROS) ? 2'h3 : 2'h0;
				end
				2'h3: begin
					d.trs  = (video_word_i == WORD_ONES) ? 2'h1 : 2'h0;
					is_eav = video_word_i[XYZ_H_BIT];
					if (!is_eav) begin
						d.in_act = 1'b1;
						d.acnt   = '0;
					end
				end
				default: d.trs = 2'h0;
			endcase
		end

		if (is_eav) begin
			d.wcnt      = '0;
			d.tot_words = q.wcnt + 13'h1; // RULE7
			d.f_prev    = f_bit;
			d.lcnt      = q.lcnt + 11'h1;
			if (!v_bit && !f_bit) d.alcnt = q.alcnt + 11'h1;
			// Field 2 to field 1 marks a new frame
			if (q.f_prev && !f_bit) begin
				d.framed    = 1'b1;
				d.lcnt      = 11'h1;
				d.alcnt     = v_bit ? 11'h0 : 11'h1;
				same = (q.lcnt == q.tot_lines) && (q.alcnt == q.act_lines);
				if (q.framed) begin
					d.tot_lines = q.lcnt; // RULE7
					d.act_lines = q.alcnt; // RULE7
				end
				// Flywheel lock needs repeated identical frames
				if (same && q.tot_lines != '0) begin
					if (q.repeats != LOCK_REPEATS) d.repeats = q.repeats + 2'h1;
				end else begin
					d.repeats = '0;
				end
				d.standard_locked = (d.repeats == LOCK_REPEATS); // RULE9
			end
		end

		if (!run) begin
			d = '0; // RULE10
			d.rdata = keep_rdata;
		end

		if (!locked_i) d.fmt = FMT_UNKNOWN; // RULE13
		else if (async_transport_mode_in_i) d.fmt = FMT_ASYNC; // RULE12
		else if (!video_processing_bypass_n_i) d.fmt = FMT_UNKNOWN; // RULE13
		else if (d.standard_locked) d.fmt = FMT_VIDEO; // RULE12
		else d.fmt = FMT_UNKNOWN;

		if (reg_rd_i) d.rdata = read_reg(reg_addr_i, q, pid_bytes, pid_version);

		if (!reset_n_i) begin
			d     = '0; // RULE10
			d.fmt = FMT_UNKNOWN; // RULE13
		end
	end

	always_ff @(posedge clk_i) begin
		q <= d;
	end

	assign reg_rdata_o       = q.rdata;
	assign standard_locked_o = q.standard_locked;
	assign data_format_o     = q.fmt;
endmodule
`default_nettype wire

// ---- verif/fmt_chk.sv ----
// Checker: port rules of the format detector.
// Bound to every detector instance.
`timescale 1ns/10ps
`default_nettype none
module fmt_chk
	import sd_fmt_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        reset_n_i,
	input wire logic        locked_i,
	input wire logic        video_processing_bypass_n_i,
	input wire logic        async_transport_mode_in_i,
	input wire logic [7:0]  reg_addr_i,
	input wire logic        reg_rd_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic        standard_locked_o,
	input wire logic [3:0]  data_format_o
);
	wire logic       byp = !video_processing_bypass_n_i;
	wire logic       asy = async_transport_mode_in_i;
	wire logic       lost = !locked_i || byp;
	wire logic [3:0] fmt = data_format_o;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	a_unlock_code: assert property (!locked_i |=> fmt == FMT_UNKNOWN)
		else $error("code set unlocked");
	a_idle_code: assert property (byp && !asy |=> fmt == FMT_UNKNOWN)
		else $error("code set idle");
	a_async_code: assert property (locked_i && asy |=> fmt == FMT_ASYNC)
		else $error("no async code");
	a_lost_std: assert property (lost |=> !standard_locked_o)
		else $error("lock kept");
	a_status_map: assert property (reg_rd_i && reg_addr_i == ADDR_STATUS |=>
		{reg_rdata_o[15:8], reg_rdata_o[6:0]} == {10'h000, $past(standard_locked_o), $past(fmt)})
		else $error("status mismatch");
	a_rd_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data moved");
	a_lines_top: assert property (reg_rd_i && reg_addr_i == ADDR_TOT_LINES |=>
		reg_rdata_o[15:11] == 5'h00) else $error("upper bits set");
	a_lost_clear: assert property (lost ##1 lost && reg_rd_i &&
		reg_addr_i inside {[ADDR_PID_LOW:ADDR_ACT_LINES]} |=> reg_rdata_o == 16'h0000)
		else $error("not cleared");
endmodule
bind sd_video_format_detector fmt_chk fmt_chk_i (.*);
`default_nettype wire

// ---- verif/video_source.sv ----
// Partner: 525-line stream of 22-word lines, payload packet on one line.
// Assumes controls change just after clk_i rises; needs no reset.
`timescale 1ns/10ps
`default_nettype none
module video_source
	import sd_fmt_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic [31:0] bytes_i,
	input  wire logic [10:0] line_i,
	input  wire logic        bad_i,
	input  wire logic        gap_i,
	output var logic  [9:0]  word_o = 10'h000,
	output var logic         valid_o = 1'b0
);
	int          ln = 520;
	int          w = 0;
	logic [9:0]  pk [11];
	logic [55:0] d;
	logic [8:0]  s;
	function automatic logic [9:0] par(input logic [7:0] b);
		return {~^b, ^b, b};
	endfunction
	function automatic logic [9:0] xyz(input logic h);
		logic f;
		logic v;
		f = ln > 262;
		v = ln < 20 || (f && ln < 283);
		return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h, 2'b00};
	endfunction
	always_comb begin
		d = {bytes_i, PID_COUNT, PID_SDID, PID_DID};
		s = 9'h000;
		pk[0] = WORD_ZEROS;
		pk[1] = WORD_ONES;
		pk[2] = WORD_ONES;
		for (int k = 3; k < 10; k++) begin
			pk[k] = par(d[8 * k - 24 +: 8]);
			s = s + pk[k][8:0];
		end
		// A bad checksum flips only bit 0, so bit 9 still looks consistent
		pk[10] = {~s[8], s ^ {8'h00, bad_i}};
	end
	always @(posedge clk_i) begin
		#1;
		if (gap_i && valid_o) begin
			valid_o = 1'b0;
			word_o = ~word_o;
		end else begin
			valid_o = 1'b1;
			case (w)
				0, 16: word_o = WORD_ONES;
				1, 2, 17, 18: word_o = WORD_ZEROS;
				3: word_o = xyz(1'b1);
				19: word_o = xyz(1'b0);
				20, 21: word_o = 10'h200;
				default: word_o = (ln == line_i && w < 15) ? pk[w - 4] : 10'h040;
			endcase
			w = (w + 1) % 22;
			if (w == 0) ln = ln % 525 + 1;
		end
	end
endmodule
`default_nettype wire

// ---- verif/sd_video_format_detector_tb.sv ----
// Bench: detector fed by the word source, checked through host reads.
// Assumes the checker arrives by bind.
`timescale 1ns/10ps
`default_nettype none
module sd_video_format_detector_tb;
	import sd_fmt_pkg::*;
	typedef struct {logic [7:0] a; logic [15:0] e;} row_t;
	logic        clk_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic        locked_i = 1'b1;
	logic        video_processing_bypass_n_i = 1'b1;
	logic        async_transport_mode_in_i = 1'b0;
	logic        reg_rd_i = 1'b0;
	logic        bad = 1'b0;
	logic        gap = 1'b0;
	logic [7:0]  reg_addr_i = 8'h00;
	logic [10:0] line = 11'h00a;
	logic [31:0] pid = 32'h4433_2291;
	logic [9:0]  video_word_i;
	logic        word_valid_i;
	logic [15:0] reg_rdata_o;
	logic        standard_locked_o;
	logic [3:0]  data_format_o;
	int          fails = 0;
	int          checked = 0;
	row_t        rows [8] = '{'{ADDR_STATUS, 16'h0096}, '{ADDR_PID_LOW, 16'h2291},
		'{ADDR_PID_HIGH, 16'h4433}, '{ADDR_TOT_LINES, 16'h020d}, '{ADDR_TOT_WORDS, 16'h0016},
		'{ADDR_ACT_WORDS, 16'h0002}, '{ADDR_ACT_LINES, 16'h00f3}, '{8'h05, 16'h0000}};
	always #25 clk_i = ~clk_i;
	sd_video_format_detector sd_video_format_detector_i (.*);
	video_source video_source_i (.clk_i(clk_i), .bytes_i(pid), .line_i(line), .bad_i(bad),
		.gap_i(gap), .word_o(video_word_i), .valid_o(word_valid_i));
	task automatic tick();
		@(posedge clk_i) #1;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] e);
		checked++;
		if (got !== e) begin
			fails++;
			$display("unexpected %0t got %h want %h", $time, got, e);
		end
	endtask
	task automatic check(input logic [7:0] a, input logic [15:0] e);
		tick();
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		tick();
		reg_rd_i = 1'b0;
		cmp(reg_rdata_o, e);
	endtask
	task automatic cleared();
		foreach (rows[i]) check(rows[i].a, rows[i].a == ADDR_STATUS ? 16'h000f : 16'h0000);
	endtask
	task automatic end_of_test();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (100000) tick();
		fails++;
		end_of_test();
	end
	initial begin
		repeat (8) tick();
		reset_n_i = 1'b1;
		cleared();
		$display("test reset done");
		for (int i = 0; i < 70000 && standard_locked_o !== 1'b1; i++) tick();
		foreach (rows[i]) check(rows[i].a, rows[i].e);
		cmp({15'h0000, standard_locked_o}, 16'h0001);
		$display("test rows done");
		// Half-rate words over a whole frame with a bad checksum, then a full-rate frame with a good one on a wrong line
		bad = 1'b1;
		gap = 1'b1;
		pid = 32'h0102_0304;
		repeat (23100) tick();
		bad = 1'b0;
		gap = 1'b0;
		line = 11'h00b;
		repeat (11550) tick();
		check(ADDR_PID_LOW, 16'h2291);
		check(ADDR_PID_HIGH, 16'h4433);
		check(ADDR_STATUS, 16'h0096);
		$display("test refuse done");
		// A good version 0 packet on the right line replaces the whole set
		line = 11'h00a;
		repeat (11550) tick();
		check(ADDR_PID_LOW, 16'h0304);
		check(ADDR_PID_HIGH, 16'h0102);
		check(ADDR_STATUS, 16'h0016);
		$display("test version done");
		video_processing_bypass_n_i = 1'b0;
		cleared();
		cmp({15'h0000, standard_locked_o}, 16'h0000);
		video_processing_bypass_n_i = 1'b1;
		async_transport_mode_in_i = 1'b1;
		repeat (2) tick();
		cmp({12'h000, data_format_o}, {12'h000, FMT_ASYNC});
		locked_i = 1'b0;
		repeat (2) tick();
		cmp({12'h000, data_format_o}, {12'h000, FMT_UNKNOWN});
		check(ADDR_TOT_LINES, 16'h0000);
		$display("test modes done");
		end_of_test();
	end
endmodule
`default_nettype wire
